// ==== rtl/phb_pkg.sv ====
// package for the host bus port: address map, bus widths, timing counts
// assumes a 200 MHz core clock; inputs already synchronous to it
`default_nettype none
package phb_pkg;
    // ------------------------------------------------------------------
    // widths and address fields
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int LOW_ADDR_HI = 2;
    localparam int LOW_ADDR_LO = 1;
    localparam int UP_ADDR_HI = 7;
    localparam int UP_ADDR_LO = 3;
    // ------------------------------------------------------------------
    // resource map, word index a[7:3] (own layout of the port)
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_RX_DATA = 5'h00;
    localparam logic [4:0] IDX_TX_DATA = 5'h04;
    localparam logic [4:0] IDX_RX_STS = 5'h08;
    localparam logic [4:0] IDX_TX_STS = 5'h09;
    localparam logic [4:0] IDX_CSR_LO = 5'h0A;
    // ------------------------------------------------------------------
    // burst limits and timing
    // ------------------------------------------------------------------
    localparam logic [4:0] BURST_MAX_DW = 5'h08;
    localparam logic [4:0] BURST_MAX_W = 5'h10;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_DSU_NS = 7;
    localparam int T_DOFF_NS = 7;
    // longest time, rounded down, at least one cycle
    localparam int T_DOFF_CYC = (T_DOFF_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1
        : (T_DOFF_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

    // request to the core side
    typedef struct packed {
        logic rd;
        logic wr;
        logic fifo;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } phb_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } phb_state_t;
endpackage
`default_nettype wire

// ==== rtl/phb_port.sv ====
// host bus port: strobe decode, read snapshot, write capture, burst count
// assumes strobes, address and data are already synchronous to CLK_I
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: read starts only when select and read strobe are both low.
// RL2: read ends when either strobe rises.
// RL3: counters are snapshotted at read start, held steady for the access.
// RL4: reads reach csrs, rx data fifo, rx and tx status fifos.
// RL5: in 16-bit mode upper data half is never driven on reads.
// RL6: normal burst limited to 8 dwords or 16 words.
// RL7: host keeps strobes high at least 13 ns between accesses.
// RL8: fifo select high makes every read pop the rx data fifo.
// RL9: in fifo mode a[2:1] still used, a[7:3] ignored.
// RL10: fifo-select bursts have no length limit.
// RL11: in fifo bursts host holds a raised strobe high 13 ns.
// RL12: host drives fifo select with address timing.
// RL13: write begins with select and write low, ends when either rises.
// RL14: in 16-bit mode upper data half is ignored on writes.
// RL15: fifo select high makes every write push the tx data fifo.
// RL16: host holds read strobes 32 ns, spaces reads 45 ns.
// RL17: host holds write strobes 32 ns, spaces writes 45 ns.
// RL18: write data is captured at the first rising strobe edge.
// RL19: data drivers enabled only while a read is in progress; the registered enables here turn on and off one cycle after the read.
module phb_port (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic HOST_SELECT_N_I,
    input wire logic READ_STROBE_N_I,
    input wire logic WRITE_STROBE_N_I,
    input wire logic FIFO_SEL_I,
    input wire logic BUS16_I,
    input wire logic [phb_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [phb_pkg::DATA_W-1:0] DATA_I,
    output logic [phb_pkg::DATA_W-1:0] DATA_O,
    output logic DATA_OE_HI_O,
    output logic DATA_OE_LO_O,
    // core side: csr file, counters and fifo heads
    input wire logic [phb_pkg::DATA_W-1:0] CSR_DATA_I,
    input wire logic [phb_pkg::DATA_W-1:0] CNT_DATA_I,
    input wire logic [phb_pkg::DATA_W-1:0] RX_DATA_I,
    input wire logic [phb_pkg::DATA_W-1:0] RX_STS_I,
    input wire logic [phb_pkg::DATA_W-1:0] TX_STS_I,
    output logic [phb_pkg::ADDR_W-1:0] CSR_ADDR_O,
    output logic CSR_WR_O,
    output logic [phb_pkg::DATA_W-1:0] WR_DATA_O,
    output logic RX_POP_O,
    output logic RX_STS_POP_O,
    output logic TX_STS_POP_O,
    output logic TX_PUSH_O,
    output logic BURST_OVER_O
);
    // ------------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------------
    // an access exists only while select and its strobe are both low;
    // either one rising ends it, so the order of the edges is free
    wire logic sel_low = !HOST_SELECT_N_I;
    wire logic rd_low = !READ_STROBE_N_I;
    wire logic wr_low = !WRITE_STROBE_N_I;
    wire logic rd_act = sel_low && rd_low; // RL1 RL2
    wire logic wr_act = sel_low && wr_low; // RL13

    // resource index from a[7:3]; a[2:1] only pick the word inside it
    wire logic [4:0] up_idx =
        ADDR_I[phb_pkg::UP_ADDR_HI:phb_pkg::UP_ADDR_LO];

    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    phb_pkg::phb_state_t state;
    phb_pkg::phb_state_t next_state;
    logic [phb_pkg::ADDR_W-1:0] last_addr;
    logic [4:0] beat_cnt;
    logic [4:0] next_beat_cnt;
    // write request resampled each cycle while the write strobes stay low, held after they rise
    phb_pkg::phb_req_t wr_req;
    phb_pkg::phb_req_t next_wr_req;

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    // fifo select forces the rx data slot; a[2:1] are kept as they come
    wire logic [4:0] eff_idx = FIFO_SEL_I
        ? phb_pkg::IDX_RX_DATA
        : up_idx; // RL8 RL9
    wire logic sel_rx = eff_idx[4:2] == phb_pkg::IDX_RX_DATA[4:2]; // RL4
    wire logic sel_rsts = eff_idx == phb_pkg::IDX_RX_STS;
    wire logic sel_tsts = eff_idx == phb_pkg::IDX_TX_STS;
    wire logic sel_cnt = eff_idx == phb_pkg::IDX_CSR_LO;

    // fifo heads first, then counters, then the plain csr file
    wire logic [phb_pkg::DATA_W-1:0] rd_mux = sel_rx ? RX_DATA_I
        : sel_rsts ? RX_STS_I
        : sel_tsts ? TX_STS_I
        : sel_cnt ? CNT_DATA_I
        : CSR_DATA_I; // RL4

    // ------------------------------------------------------------------
    // burst beats
    // ------------------------------------------------------------------
    // a new beat inside a burst is an address change while strobes hold;
    // a host may park on one address, so only a change counts as a beat
    wire logic in_read = state == phb_pkg::ST_READ;
    wire logic addr_moved = ADDR_I != last_addr;
    wire logic rd_start = rd_act && !in_read; // RL1
    wire logic rd_beat = rd_act && in_read && addr_moved;
    wire logic [4:0] burst_lim = BUS16_I
        ? phb_pkg::BURST_MAX_W
        : phb_pkg::BURST_MAX_DW; // RL6

    // beats past the limit are refused, except in fifo mode
    wire logic beat_ok = FIFO_SEL_I || (beat_cnt < burst_lim); // RL6 RL10
    wire logic beat_refused = rd_beat && !beat_ok; // RL6
    wire logic take = rd_start || (rd_beat && beat_ok);

    // refused beats do not count, so a normal burst parks at its limit;
    // in fifo mode the count may wrap, which nothing there depends on
    always_comb begin
        next_beat_cnt = beat_cnt;
        if (rd_start) begin
            next_beat_cnt = 5'h01;
        end else if (rd_beat && beat_ok) begin
            next_beat_cnt = beat_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // access state
    // ------------------------------------------------------------------
    // state holds a read or a write, never both; the first one seen wins, a read if both start together
    always_comb begin
        case (state)
            phb_pkg::ST_IDLE: begin
                next_state = rd_act ? phb_pkg::ST_READ
                    : wr_act ? phb_pkg::ST_WRITE : phb_pkg::ST_IDLE;
            end
            phb_pkg::ST_READ: begin
                next_state = rd_act ? phb_pkg::ST_READ
                    : phb_pkg::ST_IDLE; // RL2
            end
            phb_pkg::ST_WRITE: begin
                next_state = wr_act ? phb_pkg::ST_WRITE
                    : phb_pkg::ST_IDLE; // RL13
            end
            default: begin
                next_state = phb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= phb_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // last address seen while the read strobes hold; refused beats move
    // it as well, so each refused beat is flagged once, not every cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            last_addr <= '0;
        end else if (rd_act) begin
            last_addr <= ADDR_I;
        end
    end

    // beats accepted in the current read
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            beat_cnt <= 5'h00;
        end else begin
            beat_cnt <= next_beat_cnt; // RL6
        end
    end

    // ------------------------------------------------------------------
    // read data and drivers
    // ------------------------------------------------------------------
    // snapshot per beat so counters stay still for the whole access
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DATA_O <= phb_pkg::RST_DATA;
        end else if (take) begin
            DATA_O <= rd_mux; // RL3
        end
    end

    // lane enables: lane 0 is the low half, lane 1 the high half
    wire logic [1:0] lane_en;
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++) begin : g_lane
            if (lane == 0) begin : g_lo
                assign lane_en[lane] = rd_act; // RL19
            end else begin : g_hi
                assign lane_en[lane] = rd_act && !BUS16_I; // RL5
            end
        end
    endgenerate

    // drivers on only during a read; registered, so they follow by one
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DATA_OE_LO_O <= 1'b0;
            DATA_OE_HI_O <= 1'b0;
        end else begin
            DATA_OE_LO_O <= lane_en[0]; // RL19
            DATA_OE_HI_O <= lane_en[1]; // RL5
        end
    end

    // pops are one-cycle pulses on each accepted beat
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RX_POP_O <= 1'b0;
            RX_STS_POP_O <= 1'b0;
            TX_STS_POP_O <= 1'b0;
            BURST_OVER_O <= 1'b0;
        end else begin
            RX_POP_O <= take && sel_rx; // RL8
            RX_STS_POP_O <= take && sel_rsts;
            TX_STS_POP_O <= take && sel_tsts;
            BURST_OVER_O <= beat_refused; // RL6
        end
    end

    // ------------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------------
    // data tracks the bus while strobes are low; the value held at the
    // first rising strobe is the one committed
    wire logic [phb_pkg::DATA_W-1:0] wr_in = BUS16_I
        ? {{phb_pkg::HALF_W{1'b0}}, DATA_I[phb_pkg::HALF_W-1:0]}
        : DATA_I; // RL14

    // request follows the pins each cycle of a write; the read flag has
    // no use on this path and stays zero
    always_comb begin
        next_wr_req = wr_req;
        next_wr_req.rd = 1'b0;
        next_wr_req.wr = wr_act; // RL13
        if (wr_act) begin
            next_wr_req.fifo = FIFO_SEL_I; // RL15
            next_wr_req.addr = ADDR_I;
            next_wr_req.data = wr_in; // RL18
        end
    end

    // held request; it keeps the last sample taken before the strobe rose
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_req <= '0;
        end else begin
            wr_req <= next_wr_req;
        end
    end

    // commit at the first edge that sees the strobes no longer both low
    wire logic wr_end = (state == phb_pkg::ST_WRITE)
        && !wr_act; // RL18
    wire logic [2:0] wr_grp =
        wr_req.addr[phb_pkg::UP_ADDR_HI:phb_pkg::UP_ADDR_LO+2];
    wire logic wr_to_tx = wr_req.fifo
        || wr_grp == phb_pkg::IDX_TX_DATA[4:2]; // RL15
    wire logic wr_to_rx = wr_grp == phb_pkg::IDX_RX_DATA[4:2];
    // writes aimed at the rx data slot are dropped on purpose
    wire logic wr_to_csr = !wr_to_tx && !wr_to_rx;

    // one-cycle write pulses
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CSR_WR_O <= 1'b0;
            TX_PUSH_O <= 1'b0;
        end else begin
            TX_PUSH_O <= wr_end && wr_to_tx; // RL15
            CSR_WR_O <= wr_end && wr_to_csr; // RL13
        end
    end

    // data and address stand from one commit to the next
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WR_DATA_O <= phb_pkg::RST_DATA;
            CSR_ADDR_O <= '0;
        end else if (wr_end) begin
            WR_DATA_O <= wr_req.data; // RL14
            CSR_ADDR_O <= wr_req.addr;
        end
    end
endmodule // phb_port
`default_nettype wire

// ==== tb/phb_port_asserts.sv ====
// checker: pin timing of the host bus port
// assumes it is bound into phb_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module phb_port_asserts (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic HOST_SELECT_N_I,
    input wire logic READ_STROBE_N_I,
    input wire logic WRITE_STROBE_N_I,
    input wire logic FIFO_SEL_I,
    input wire logic BUS16_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] DATA_I,
    input wire logic DATA_OE_HI_O,
    input wire logic DATA_OE_LO_O,
    input wire logic RX_POP_O,
    input wire logic RX_STS_POP_O,
    input wire logic CSR_WR_O,
    input wire logic TX_PUSH_O,
    input wire logic [31:0] WR_DATA_O,
    input wire logic BURST_OVER_O
);
    // one flag per strobe pair; latency of one or two edges is tolerated
    wire logic rd_off = HOST_SELECT_N_I | READ_STROBE_N_I;
    wire logic wr_off = HOST_SELECT_N_I | WRITE_STROBE_N_I;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_rd_start_oe: assert property ($fell(rd_off) && WRITE_STROBE_N_I
        |-> ##[1:2] DATA_OE_LO_O) else $error("read did not drive");
    a_idle_no_oe: assert property (rd_off [*4] |-> !DATA_OE_LO_O)
        else $error("drivers on outside a read");
    a_hi_half_off: assert property (BUS16_I && $past(BUS16_I)
        |-> !DATA_OE_HI_O) else $error("upper half driven in 16-bit mode");
    a_sts_pop_addr: assert property (RX_STS_POP_O
        |-> $past(ADDR_I[7:3]) == 5'h08 && !$past(FIFO_SEL_I))
        else $error("status pop without its address");
    a_fifo_rd_pop: assert property ($rose(DATA_OE_LO_O)
        && $past(FIFO_SEL_I) |-> RX_POP_O)
        else $error("fifo read did not pop");
    a_fifo_wr_push: assert property (!wr_off && FIFO_SEL_I
        ##1 wr_off |-> ##[1:2] TX_PUSH_O)
        else $error("fifo write did not push");
    a_wr_cause: assert property (CSR_WR_O || TX_PUSH_O
        |-> !$past(HOST_SELECT_N_I, 3) && !$past(WRITE_STROBE_N_I, 3))
        else $error("write pulse without a write");
    a_wr_data_cap: assert property (CSR_WR_O || TX_PUSH_O
        |-> WR_DATA_O == ($past(BUS16_I, 3)
        ? {16'h0000, $past(DATA_I[15:0], 3)} : $past(DATA_I, 3)))
        else $error("write data wrong");
    a_burst_cap: assert property (BURST_OVER_O
        |-> !RX_POP_O && !$past(FIFO_SEL_I)) else $error("refused beat popped");
    c_over: cover property (BURST_OVER_O);
    c_sts: cover property (RX_STS_POP_O);
    c_csr: cover property (CSR_WR_O);
endmodule // phb_port_asserts
bind phb_port phb_port_asserts phb_port_asserts_inst (.CLK_I, .RST_N_I,
    .HOST_SELECT_N_I, .READ_STROBE_N_I, .WRITE_STROBE_N_I, .FIFO_SEL_I,
    .BUS16_I, .ADDR_I, .DATA_I, .DATA_OE_HI_O, .DATA_OE_LO_O, .RX_POP_O,
    .RX_STS_POP_O, .CSR_WR_O, .TX_PUSH_O, .WR_DATA_O, .BURST_OVER_O);
`default_nettype wire

// ==== tb/phb_host.sv ====
// host model: strobes, address and data of a bus controller
// assumes the port samples its pins on the rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module phb_host (
    input wire logic clk_i,
    output logic sel_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic fifo_o,
    output logic bus16_o,
    output logic [7:0] addr_o,
    output logic [31:0] data_o
);
    initial begin
        {sel_n_o, rd_n_o, wr_n_o} = 3'h7;
        {fifo_o, bus16_o, addr_o, data_o} = 42'h0;
    end
    // fifo select moves with the address, zero setup
    task automatic go(input logic w, f, b16, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        {fifo_o, bus16_o, addr_o, data_o} <= {f, b16, a, d};
        sel_n_o <= 1'h0;
        rd_n_o <= w;
        wr_n_o <= !w;
    endtask
    task automatic beat(input logic [7:0] a);
        repeat (9) @(posedge clk_i);
        addr_o <= a;
    endtask
    // released data inverts so a late capture cannot pass by luck
    task automatic stop();
        repeat (7) @(posedge clk_i);
        {sel_n_o, rd_n_o, wr_n_o} <= 3'h7;
        data_o <= ~data_o;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // phb_host
`default_nettype wire

// ==== tb/phb_port_tb_top.sv ====
// testbench: random accesses and bursts against a bench model
// assumes phb_pkg, phb_port, phb_host and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module phb_port_tb_top;
    logic CLK_I, RST_N_I, HOST_SELECT_N_I, READ_STROBE_N_I, WRITE_STROBE_N_I;
    logic FIFO_SEL_I, BUS16_I, DATA_OE_HI_O, DATA_OE_LO_O, CSR_WR_O, RX_POP_O;
    logic RX_STS_POP_O, TX_STS_POP_O, TX_PUSH_O, BURST_OVER_O;
    logic [7:0] ADDR_I, CSR_ADDR_O, wa;
    logic [31:0] DATA_I, DATA_O, CSR_DATA_I, CNT_DATA_I, RX_DATA_I, wd;
    logic [31:0] RX_STS_I, TX_STS_I, WR_DATA_O, seed = 32'hD69C2BD4;
    int num_errors = 0, checks_done = 0, pops = 0, overs = 0, nc = 0, nt = 0;
    logic [31:0] exp_q[$];
    phb_port phb_port_inst (.CLK_I, .RST_N_I, .HOST_SELECT_N_I,
        .READ_STROBE_N_I, .WRITE_STROBE_N_I, .FIFO_SEL_I, .BUS16_I, .ADDR_I,
        .DATA_I, .DATA_O, .DATA_OE_HI_O, .DATA_OE_LO_O, .CSR_DATA_I,
        .CNT_DATA_I, .RX_DATA_I, .RX_STS_I, .TX_STS_I, .CSR_ADDR_O, .CSR_WR_O,
        .WR_DATA_O, .RX_POP_O, .RX_STS_POP_O, .TX_STS_POP_O, .TX_PUSH_O,
        .BURST_OVER_O);
    phb_host phb_host_inst (.clk_i(CLK_I), .sel_n_o(HOST_SELECT_N_I),
        .rd_n_o(READ_STROBE_N_I), .wr_n_o(WRITE_STROBE_N_I),
        .fifo_o(FIFO_SEL_I), .bus16_o(BUS16_I), .addr_o(ADDR_I),
        .data_o(DATA_I));
    initial begin
        CLK_I = 1'h0;
        forever #2.5 CLK_I = ~CLK_I;
    end
    // one-cycle pulses are counted at the edge after they appear
    always @(posedge CLK_I) begin
        pops += (RX_POP_O === 1'h1);
        overs += (BURST_OVER_O === 1'h1);
        if (CSR_WR_O === 1'h1) {nc, wd, wa} = {nc + 1, WR_DATA_O, CSR_ADDR_O};
        if (TX_PUSH_O === 1'h1) {nt, wd} = {nt + 1, WR_DATA_O};
    end
    function logic [31:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude();
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task refresh();
        @(posedge CLK_I);
        {CSR_DATA_I, CNT_DATA_I, RX_DATA_I} <= {nxt(), nxt(), nxt()};
        {RX_STS_I, TX_STS_I} <= {nxt(), nxt()};
        #1;
    endtask
    // one access; reads never aim at the transmit data slots
    task automatic access(input logic w, f, b16, input logic [4:0] x);
        logic [31:0] m, e, d;
        int t0, c0, i;
        m = b16 ? 32'h0000FFFF : 32'hFFFFFFFF;
        if (!w && x[4:2] == 3'h1) x = 5'h0B;
        refresh();
        e = (f || x < 5'h04) ? RX_DATA_I : x == 5'h08 ? RX_STS_I :
            x == 5'h09 ? TX_STS_I : x == 5'h0A ? CNT_DATA_I : CSR_DATA_I;
        {t0, c0, d} = {nt, nc, nxt()};
        phb_host_inst.go(w, f, b16, {x, d[2:1], 1'h0}, d);
        if (w) begin
            phb_host_inst.stop();
            #1;
            chk(nt - t0, f || x[4:2] == 3'h1);
            chk(nc - c0, !f && x > 5'h07);
            if (f || x > 5'h03) exp_q.push_back(d & m);
            if (exp_q.size() > 0) chk(wd, exp_q.pop_front());
            if (!f && x > 5'h07) chk(wa, {x, d[2:1], 1'h0});
        end else begin
            for (i = 0; i < 20 && DATA_OE_LO_O !== 1'h1; i++)
                @(posedge CLK_I) #1;
            if (i == 20) begin
                num_errors++;
                conclude();
            end
            chk(DATA_O & m, e & m);
            chk({RX_POP_O, RX_STS_POP_O, TX_STS_POP_O},
                {f || x < 5'h04, !f && x == 5'h08, !f && x == 5'h09});
            chk(DATA_OE_HI_O, !b16);
            refresh();
            chk(DATA_O & m, e & m);
            phb_host_inst.stop();
            #1;
            chk(DATA_OE_LO_O, 1'h0);
        end
    endtask
    // eighteen beats; only fifo mode takes them all
    task automatic burst(input logic f, b16, input logic [2:0] up);
        int p0, o0, n;
        {p0, o0, n} = {pops, overs, f ? 18 : b16 ? 16 : 8};
        phb_host_inst.go(1'h0, f, b16, {up, 5'h00}, 32'h0);
        for (int k = 1; k < 18; k++) phb_host_inst.beat({up, k[3:0], 1'h0});
        phb_host_inst.stop();
        chk(pops - p0, n);
        chk(overs - o0, 18 - n);
    endtask
    initial begin
        {RST_N_I, CSR_DATA_I, CNT_DATA_I, RX_DATA_I} = 97'h0;
        {RX_STS_I, TX_STS_I} = 64'h0;
        repeat (6) @(posedge CLK_I);
        RST_N_I <= 1'h1;
        for (int n = 0; n < 48; n++) begin
            seed = nxt();
            access(seed[0], seed[1] & seed[2], seed[3], seed[8:4]);
        end
        burst(1'h0, 1'h0, 3'h0);
        burst(1'h0, 1'h1, 3'h0);
        burst(1'h1, 1'h1, 3'h5);
        conclude();
    end
endmodule // phb_port_tb_top
`default_nettype wire
